// File: rtl/tpwl_map.svh
// Timing constants for the thermistor pulse width link
// Assumes a 100 MHz core clock; all counts are derived from printed times
`ifndef TPWL_MAP_SVH
`define TPWL_MAP_SVH
`define TPWL_CLK_MHZ          100
`define TPWL_GLITCH_NS        500
`define TPWL_GLITCH_CYC       ((`TPWL_GLITCH_NS * `TPWL_CLK_MHZ) / 1000)
`define TPWL_START_US         5
`define TPWL_START_CYC        (`TPWL_START_US * `TPWL_CLK_MHZ)
`define TPWL_READY_US         125
`define TPWL_READY_CYC        (`TPWL_READY_US * `TPWL_CLK_MHZ)
`define TPWL_CONV_MS          102
`define TPWL_CONV_CYC         (`TPWL_CONV_MS * 1000 * `TPWL_CLK_MHZ)
`define TPWL_LOW_US           4900
`define TPWL_LOW_CYC          (`TPWL_LOW_US * `TPWL_CLK_MHZ)
`define TPWL_OFFSET_PPM       200
`define TPWL_FAULT_PCT        5
`define TPWL_FAULT_FRAC       16'h0666
`define TPWL_FAULT_SHIFT      17
`define TPWL_RATIO_SHIFT      16
`define TPWL_PPM_SCALE        1000000
`define TPWL_CHANNELS         4
`endif

// File: rtl/tpwl_pkg.sv
// Types for the thermistor pulse width link
// Assumes the constants of tpwl_map.svh
package tpwl_pkg;
    typedef enum logic [2:0] {
        TPWL_SLEEP,
        TPWL_START,
        TPWL_CONVERT,
        TPWL_READY,
        TPWL_HIGH,
        TPWL_LOW
    } tpwl_state_e;
endpackage : tpwl_pkg

// File: rtl/tpwl_deglitch.sv
// Line input synchroniser and glitch filter
// Assumes line_i is asynchronous to clk_i; output changes only after a stable run
`timescale 1ns/1ps
`default_nettype none
`include "tpwl_map.svh"
module tpwl_deglitch #(
    parameter int unsigned FILT_CYC = `TPWL_GLITCH_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic line_i,
    output var  logic line_o
);
    logic        sync_a;
    logic        sync_b;
    logic [15:0] run;
    logic [15:0] next_run;
    logic        next_line;

    // Count cycles the synced level differs from the filtered level
    always_comb begin
        next_run  = 16'h0000;
        next_line = line_o;
        if (sync_b != line_o) begin
            if (run >= 16'(FILT_CYC - 1)) begin
                next_line = sync_b; // RULE_11
            end else begin
                next_run = run + 16'h0001;
            end
        end
    end

    // Two-stage synchroniser and filter state; line idles high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            run    <= 16'h0000;
            line_o <= 1'b1;
        end else begin
            sync_a <= line_i;
            sync_b <= sync_a;
            run    <= next_run;
            line_o <= next_line;
        end
    end
endmodule : tpwl_deglitch
`default_nettype wire

// File: rtl/tpwl_link.sv
// Device side of the single-wire thermistor pulse width link
// Assumes an external pull-up on the line and per-channel resistor_voltage codes
// Function
// [RULE_01] Idle in sleep with the line released so the pull-up holds it high.
// [RULE_02] The controller starts a measurement with a low of at least 5 us, then releases.
// [RULE_03] On release after a valid start, power the reference and scan the four channels.
// [RULE_04] Channels are energised only while a measurement is running.
// [RULE_05] After the conversion period, drive the line low for 125 us as data ready.
// [RULE_06] Then release the line for a time proportional to channel one's resistor voltage.
// [RULE_07] Each high interval is followed by a low proportional to the reference.
// [RULE_08] Four high/low pairs are sent, then the line is released and the device sleeps.
// [RULE_09] High over low equals resistor over reference voltage minus 0.0002.
// [RULE_10] An open or shorted channel yields a high shorter than 5% of the low.
// [RULE_11] Line disturbances shorter than about 500 ns are ignored.
// [RULE_12] Both sides only pull the line low; a released line reads high.
// [RULE_13] The controller times each interval and flags ratios under the fault limit.
`timescale 1ns/1ps
`default_nettype none
`include "tpwl_map.svh"
module tpwl_link #(
    parameter int unsigned CONV_CYC  = `TPWL_CONV_CYC,
    parameter int unsigned LOW_CYC   = `TPWL_LOW_CYC,
    parameter int unsigned READY_CYC = `TPWL_READY_CYC,
    parameter int unsigned START_CYC = `TPWL_START_CYC,
    parameter int unsigned CH_NUM    = `TPWL_CHANNELS
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        line_i,        // Shared line level
    output var  logic        line_o,        // Always low when driven
    output var  logic        line_oe_o,     // High while pulling the line low
    input  wire logic [15:0] ratio_i,       // Resistor/reference ratio, 1.0 = 16'hFFFF
    input  wire logic        fault_i,       // Selected channel open or shorted
    output var  logic [3:0]  sensor_en_o,   // One-hot channel drive, sensor_ch1 in bit 0
    output var  logic        ref_en_o,      // Reference applied to series_resistor
    output var  logic [1:0]  sel_o          // Channel whose ratio is sampled
);
    logic rst_a;
    logic rst_n;

    // Reset release through two flip-flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    logic line_f;

    // Synchronised, filtered view of the line
    tpwl_deglitch #(
        .FILT_CYC (`TPWL_GLITCH_CYC)
    ) u_deglitch (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .line_i  (line_i),
        .line_o  (line_f)
    );

    tpwl_pkg::tpwl_state_e state;
    tpwl_pkg::tpwl_state_e next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [1:0]  ch;
    logic [1:0]  next_ch;
    logic [31:0] high_len [CH_NUM];
    logic [31:0] next_high_len;
    logic        cap;
    logic        next_oe;
    logic [3:0]  next_sensor;
    logic        next_ref;
    logic [31:0] next_high_arr [CH_NUM];

    // High interval from ratio: LOW*(ratio - offset), floored at zero; a fixed short interval on fault
    function automatic logic [31:0] high_of(input logic [15:0] r, input logic f);
        logic [47:0] prod;
        logic [31:0] off;
        logic [31:0] raw;
        prod = 48'(r) * 48'(LOW_CYC);
        off  = 32'((64'(LOW_CYC) * `TPWL_OFFSET_PPM) / `TPWL_PPM_SCALE);
        raw  = 32'(prod >> `TPWL_RATIO_SHIFT);
        if (f) begin
            high_of = 32'((48'(LOW_CYC) * `TPWL_FAULT_FRAC) >> `TPWL_FAULT_SHIFT); // RULE_10
        end else if (raw > off) begin
            high_of = raw - off; // RULE_09
        end else begin
            high_of = 32'h0000_0000;
        end
    endfunction : high_of

    // Sequencer next-state logic
    always_comb begin
        next_state    = state;
        next_cnt      = cnt + 32'h0000_0001;
        next_ch       = ch;
        next_oe       = 1'b0;
        next_sensor   = 4'h0;
        next_ref      = 1'b0;
        cap           = 1'b0;
        next_high_len = high_of(ratio_i, fault_i);
        case (state)
            // Asleep with the line released until a low is seen
            tpwl_pkg::TPWL_SLEEP: begin
                next_cnt = 32'h0000_0000; // RULE_01
                if (!line_f) begin
                    next_state = tpwl_pkg::TPWL_START;
                end
            end

            // Time the start low; a short one returns to sleep
            tpwl_pkg::TPWL_START: begin
                if (line_f) begin
                    next_cnt = 32'h0000_0000;
                    if (cnt >= 32'(START_CYC - `TPWL_GLITCH_CYC)) begin // RULE_02
                        next_state = tpwl_pkg::TPWL_CONVERT; // RULE_03
                        next_ch    = 2'h0;
                    end else begin
                        next_state = tpwl_pkg::TPWL_SLEEP;
                    end
                end
            end

            // Reference on, one channel per quarter of the period
            tpwl_pkg::TPWL_CONVERT: begin
                next_ref    = 1'b1; // RULE_03
                next_sensor = 4'h1 << ch; // RULE_04
                // Each channel gets a quarter of the conversion period
                if (cnt == 32'(CONV_CYC / CH_NUM - 1)) begin
                    cap      = 1'b1;
                    next_cnt = 32'h0000_0000;
                    next_ch  = ch + 2'h1;
                    if (ch == 2'(CH_NUM - 1)) begin
                        next_state  = tpwl_pkg::TPWL_READY;
                        next_oe     = 1'b1; // RULE_05
                        next_ref    = 1'b0;
                        next_sensor = 4'h0;
                    end
                end
            end

            // Data-ready low of fixed length
            tpwl_pkg::TPWL_READY: begin
                next_oe = 1'b1; // RULE_05
                if (cnt == 32'(READY_CYC - 1)) begin
                    next_oe    = 1'b0;
                    next_cnt   = 32'h0000_0000;
                    next_state = tpwl_pkg::TPWL_HIGH; // RULE_06
                end
            end

            // Line released for the channel's high interval
            tpwl_pkg::TPWL_HIGH: begin
                if (cnt >= high_len[ch]) begin
                    next_oe    = 1'b1; // RULE_07
                    next_cnt   = 32'h0000_0000;
                    next_state = tpwl_pkg::TPWL_LOW;
                end
            end

            // Reference-proportional low, then next channel or sleep
            tpwl_pkg::TPWL_LOW: begin
                next_oe = 1'b1; // RULE_07
                if (cnt == 32'(LOW_CYC - 1)) begin
                    next_oe  = 1'b0;
                    next_cnt = 32'h0000_0000;
                    next_ch  = ch + 2'h1;
                    if (ch == 2'(CH_NUM - 1)) begin
                        next_state = tpwl_pkg::TPWL_SLEEP; // RULE_08
                    end else begin
                        next_state = tpwl_pkg::TPWL_HIGH; // RULE_08
                    end
                end
            end

            // Unused codes fall back to sleep
            default: begin
                next_state = tpwl_pkg::TPWL_SLEEP;
            end
        endcase
    end

    // Hold every captured interval; load the slot's channel at its end
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            next_high_arr[i] = high_len[i];
        end
        if (cap) begin
            next_high_arr[ch] = next_high_len; // RULE_06
        end
    end

    // Sequencer registers; line only ever driven low
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state       <= tpwl_pkg::TPWL_SLEEP;
            cnt         <= 32'h0000_0000;
            ch          <= 2'h0;
            line_oe_o   <= 1'b0;
            line_o      <= 1'b0;
            sensor_en_o <= 4'h0;
            ref_en_o    <= 1'b0;
            sel_o       <= 2'h0;
            for (int i = 0; i < CH_NUM; i++) begin
                high_len[i] <= 32'h0000_0000;
            end
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            ch          <= next_ch;
            line_oe_o   <= next_oe; // RULE_12
            line_o      <= 1'b0; // RULE_12
            sensor_en_o <= next_sensor;
            ref_en_o    <= next_ref;
            sel_o       <= next_ch;
            for (int i = 0; i < CH_NUM; i++) begin
                high_len[i] <= next_high_arr[i];
            end
        end
    end
endmodule : tpwl_link
`default_nettype wire

// File: verification/tpwl_link_monitor.sv
// Checker for the pulse width link device side
// Assumes binding to tpwl_link; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module tpwl_link_monitor #(
    parameter int unsigned READY_CYC = 50,
    parameter int unsigned LOW_CYC   = 1000
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        line_i,
    input wire logic        line_o,
    input wire logic        line_oe_o,
    input wire logic [15:0] ratio_i,
    input wire logic        fault_i,
    input wire logic [3:0]  sensor_en_o,
    input wire logic        ref_en_o,
    input wire logic [1:0]  sel_o
);
    int unsigned run;
    int unsigned next_run;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Length of the current driven low
    always_comb next_run = line_oe_o ? run + 1 : 0;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) run <= 0;
        else run <= next_run;
    end
    a_oe_drives_low: assert property (line_oe_o |-> !line_o) else $error("line driven high");
    a_sensor_onehot: assert property ($onehot0(sensor_en_o)) else $error("two channels on");
    a_power_in_conv: assert property (sensor_en_o != 4'h0 |-> ref_en_o && !line_oe_o)
        else $error("channel on outside conversion");
    a_off_in_pulses: assert property (line_oe_o |-> sensor_en_o == 4'h0 && !ref_en_o)
        else $error("power during pulses");
    a_scan_order: assert property ((sensor_en_o != 4'h0 && $past(sensor_en_o) != 4'h0
        && $changed(sensor_en_o)) |-> sensor_en_o == ($past(sensor_en_o) << 1))
        else $error("channel order wrong");
    a_ready_follows: assert property ($fell(ref_en_o) |-> ##[0:8] line_oe_o)
        else $error("no ready after conversion");
    a_low_widths: assert property ($fell(line_oe_o) |-> run == READY_CYC || run == LOW_CYC)
        else $error("low width wrong");
    a_conv_hold: assert property ($rose(ref_en_o) |-> ref_en_o [*8]) else $error("short conversion");
    a_reset_quiet: assert property (disable iff (1'b0) !reset_n_i |-> !line_oe_o && !ref_en_o)
        else $error("active in reset");
    c_ready: cover property ($fell(line_oe_o) && run == READY_CYC);
    c_last_ch: cover property (sensor_en_o == 4'h8);
    c_conv: cover property ($rose(ref_en_o));
endmodule : tpwl_link_monitor
bind tpwl_link tpwl_link_monitor #(.READY_CYC(READY_CYC), .LOW_CYC(LOW_CYC)) i_tpwl_link_monitor (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .line_i(line_i), .line_o(line_o),
    .line_oe_o(line_oe_o), .ratio_i(ratio_i), .fault_i(fault_i),
    .sensor_en_o(sensor_en_o), .ref_en_o(ref_en_o), .sel_o(sel_o));
`default_nettype wire

// File: verification/tpwl_mcu.sv
// Controller model on the shared line
// Assumes the bench resolves the open-drain wire
`timescale 1ns/1ps
`default_nettype none
module tpwl_mcu (
    input  wire logic clk_i,
    input  wire logic line_i,
    output var  logic pull_o
);
    initial pull_o = 1'b0;
    // Pull the line low for n cycles, then release
    task automatic pulse(input int n);
        @(posedge clk_i);
        pull_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        pull_o <= 1'b0;
    endtask : pulse
    // Count cycles while the line keeps one level
    task automatic span(input logic v, output int c);
        c = 0;
        while (line_i === v && c < 20000) begin
            @(posedge clk_i);
            #1;
            c++;
        end
    endtask : span
    // Start a measurement and time every interval
    task automatic run(input int n, input int g, output int conv, output int rdy,
                       output int hi[4], output int lo[4]);
        // A non-zero g splits the start low with a short high glitch
        if (g > 0) begin
            pulse(n);
            repeat (g) @(posedge clk_i);
        end
        pulse(n);
        #1;
        span(1'b1, conv);
        span(1'b0, rdy);
        for (int k = 0; k < 4; k++) begin
            span(1'b1, hi[k]);
            span(1'b0, lo[k]);
        end
    endtask : run
endmodule : tpwl_mcu
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the pulse width link
// Assumes tpwl_link and the tpwl_mcu controller model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned CONV = 400;
    localparam int unsigned LOWC = 1000;
    localparam int unsigned RDY  = 50;
    logic        clk       = 1'b0;
    logic        reset_n   = 1'b1;
    logic        line;
    logic        dut_line;
    logic        line_oe;
    logic        pull;
    logic [15:0] ratio_i   = 16'h0000;
    logic        fault_i   = 1'b0;
    logic [3:0]  sensor_en;
    logic        ref_en;
    logic [1:0]  sel;
    logic [15:0] rat [4];
    logic        flt [4];
    logic [31:0] seed      = 32'h57AE6CDF;
    int          bad_count = 0;
    int          n_compared = 0;
    int          conv;
    int          rdy;
    int          hi [4];
    int          lo [4];
    always #5 clk = ~clk;
    // Wired-AND with pull-up
    assign line = !(line_oe | pull);
    // Measured value of the selected channel
    always @(posedge clk) begin
        ratio_i <= rat[sel];
        fault_i <= flt[sel];
    end
    tpwl_link #(.CONV_CYC(CONV), .LOW_CYC(LOWC), .READY_CYC(RDY)) i_tpwl_link (
        .clk_i(clk), .reset_n_i(reset_n), .line_i(line), .line_o(dut_line),
        .line_oe_o(line_oe), .ratio_i(ratio_i), .fault_i(fault_i),
        .sensor_en_o(sensor_en), .ref_en_o(ref_en), .sel_o(sel));
    tpwl_mcu i_tpwl_mcu (.clk_i(clk), .line_i(line), .pull_o(pull));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Expected high interval in cycles; the offset is under one cycle here
    function automatic int exp_high(input logic [15:0] r);
        return int'((LOWC * r) / 65536);
    endfunction : exp_high
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    // One measurement with all intervals checked
    task automatic op(input int n, input int g);
        int e;
        i_tpwl_mcu.run(n, g, conv, rdy, hi, lo);
        check("conversion", conv >= CONV && conv <= CONV + 70, 1'b1);
        check("ready", rdy, RDY);
        for (int k = 0; k < 4; k++) begin
            e = exp_high(rat[k]);
            check("low", lo[k], LOWC);
            if (flt[k]) check("fault", hi[k] < LOWC / 20, 1'b1);
            else check("high", hi[k] + 1 >= e && hi[k] <= e + 2, 1'b1);
        end
        // Leave the line high well past the filter before the next start
        repeat (100) @(posedge clk);
        check("sleep", {dut_line, line_oe, ref_en, sensor_en}, 7'h00);
        $display("operation done");
    endtask : op
    // Main sequence: refusals, corner ratios, random ratios, faults
    initial begin
        reset_n <= 1'b0; // Falling edge at time zero starts the asynchronous reset
        rat = '{16'hFFFF, 16'h0200, 16'h8000, 16'h4000};
        flt = '{1'b0, 1'b0, 1'b0, 1'b0};
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        i_tpwl_mcu.pulse(20);
        repeat (200) @(posedge clk);
        check("glitch", ref_en, 1'b0);
        i_tpwl_mcu.pulse(300);
        repeat (200) @(posedge clk);
        check("short start", ref_en, 1'b0);
        $display("refusal tests done");
        op(300, 20);
        op(500, 0);
        for (int t = 0; t < 3; t++) begin
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                rat[k] = 16'h0200 + {1'b0, seed[14:0]};
                flt[k] = seed[20] & seed[21];
            end
            op(500 + seed[7:0], 0);
        end
        flt = '{1'b0, 1'b1, 1'b0, 1'b1};
        op(500, 0);
        summarize();
    end
    // Watchdog
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
